// file: verilog/pis_pkg.sv
// Shared constants for the periodic interrupt microframe scheduler
package pis_pkg;
  // Microframe timing at the 40 MHz block clock
  localparam int UFRAME_NS = 125000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int UFRAME_CYCLES = UFRAME_NS / CLK_PERIOD_NS;
  localparam int UFRAMES_PER_FRAME = 8;
  localparam int UFRAME_IDX_W = 3;
  localparam int FRAME_W = 11;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DESC_OFS = 12'h004;
  localparam logic [11:0] DFRAME_OFS = 12'h008;
  localparam logic [11:0] CURFRAME_OFS = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h014;

  // Descriptor word and frame number register layout
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 8;
  localparam int RESULT_LSB = 8;
  localparam int RESULT_W = 3;
  localparam int DFN_LSB = 3;
  localparam int DFN_W = 5;

  // Result code bits
  localparam int RES_ERR_BIT = 0;
  localparam int RES_BABBLE_BIT = 1;
  localparam int RES_UNDERRUN_BIT = 2;

  // Control bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIRIN_BIT = 1;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_EMPTY_BIT = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// file: verilog/pis_txn_if.sv
// Request and outcome signals between scheduler and transaction sequencer
`timescale 1ns/1ps
`default_nettype none
interface pis_txn_if;
  logic start;
  logic dirIn;
  logic busy;
  logic done;
  logic [2:0] result;
  modport sched (output start, output dirIn, input busy, input done, input result);
  modport seq (input start, input dirIn, output busy, output done, output result);
endinterface
`default_nettype wire

// file: verilog/pis_uframe_timer.sv
// Microframe tick, microframe index and frame counter
`timescale 1ns/1ps
`default_nettype none
module pis_uframe_timer #(
  parameter int UFRAME_CYCLES = pis_pkg::UFRAME_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  output logic uframeTick,
  output logic [pis_pkg::UFRAME_IDX_W-1:0] uframeIdx,
  output logic [pis_pkg::FRAME_W-1:0] frameNum
);
  import pis_pkg::*;
  localparam int CNT_W = $clog2(UFRAME_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UFRAME_CYCLES - 1);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [UFRAME_IDX_W-1:0] idx_q, idx_d;
  logic [FRAME_W-1:0] frame_q, frame_d;
  logic tick_q, tick_d;

  always_comb begin
    cnt_d = cnt_q;
    idx_d = idx_q;
    frame_d = frame_q;
    tick_d = 1'b0;
    if (enable) begin
      if (cnt_q == CNT_LAST) begin
        cnt_d = '0;
        tick_d = 1'b1;
        idx_d = idx_q + 1'b1;
        // Index wraps after microframe 7, so a new frame begins
        if (idx_q == UFRAME_IDX_W'(UFRAMES_PER_FRAME - 1)) begin
          frame_d = frame_q + 1'b1;
        end
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      idx_q <= '1;
      frame_q <= '1;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      frame_q <= frame_d;
      tick_q <= tick_d;
    end
  end

  assign uframeTick = tick_q;
  assign uframeIdx = idx_q;
  assign frameNum = frame_q;
endmodule
`default_nettype wire

// file: verilog/pis_txn_seq.sv
// Issues one interrupt transaction and encodes its outcome
`timescale 1ns/1ps
`default_nettype none
module pis_txn_seq (
  input wire logic mclk,
  input wire logic sys_rst,
  pis_txn_if.seq tx,
  output logic linkReq,
  output logic linkDirIn,
  input wire logic linkDone,
  input wire logic linkErr,
  input wire logic linkBabble,
  input wire logic linkUnderrun
);
  import pis_pkg::*;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_WAIT = 3'b010,
    SEQ_DONE = 3'b100
  } pis_seq_state_t;

  pis_seq_state_t state_q, state_d;
  logic dirIn_q, dirIn_d;
  logic [RESULT_W-1:0] result_q, result_d;

  always_comb begin
    state_d = state_q;
    dirIn_d = dirIn_q;
    result_d = result_q;
    unique case (state_q)
      SEQ_IDLE: begin
        if (tx.start) begin
          dirIn_d = tx.dirIn;
          state_d = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        // Outcome is captured only once the bus transaction has finished
        if (linkDone) begin
          result_d = '0;
          result_d[RES_ERR_BIT] = linkErr; // RULE3
          result_d[RES_BABBLE_BIT] = linkBabble & dirIn_q; // RULE3
          result_d[RES_UNDERRUN_BIT] = linkUnderrun & ~dirIn_q; // RULE3
          state_d = SEQ_DONE; // RULE2
        end
      end
      SEQ_DONE: state_d = SEQ_IDLE;
      default: state_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SEQ_IDLE;
      dirIn_q <= 1'b0;
      result_q <= '0;
    end else begin
      state_q <= state_d;
      dirIn_q <= dirIn_d;
      result_q <= result_d;
    end
  end

  assign linkReq = (state_q == SEQ_WAIT);
  assign linkDirIn = dirIn_q;
  assign tx.busy = (state_q != SEQ_IDLE);
  assign tx.done = (state_q == SEQ_DONE);
  assign tx.result = result_q;
endmodule
`default_nettype wire

// file: verilog/pis_uframe_sched.sv
// Periodic interrupt microframe scheduler with APB registers
// How it works
// RULE1: Each microframe has a 3-bit hardware-only result field at bits 8+3n.
// RULE2: A result field is written only after its bus transaction completes.
// RULE3: Result bit0 error, bit1 babble on IN, bit2 underrun on OUT.
// RULE4: Activity mask bits 7..0; software sets them, hardware clears after processing.
// RULE5: Transactions issue only when descriptor frame number equals bus frame number.
// RULE6: An all-ones mask issues a transaction in all eight microframes.
// RULE7: Mask bit n selects microframe n of the frame.
// RULE8: Microframe 7 result at bits 31..29, microframe 5 at 25..23.
`timescale 1ns/1ps
`default_nettype none
module pis_uframe_sched #(
  parameter int UFRAME_CYCLES = pis_pkg::UFRAME_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic linkReq,
  output logic linkDirIn,
  input wire logic linkDone,
  input wire logic linkErr,
  input wire logic linkBabble,
  input wire logic linkUnderrun
);
  import pis_pkg::*;

  // Bit position of a microframe's result field
  function automatic int resultLsb(input logic [UFRAME_IDX_W-1:0] n);
    resultLsb = RESULT_LSB + RESULT_W * int'(n); // RULE1 RULE8
  endfunction

  function automatic logic isAccess(input logic [11:0] ofs);
    isAccess = psel && penable && (paddr == ofs);
  endfunction

  pis_txn_if tx ();

  logic uframeTick;
  logic [UFRAME_IDX_W-1:0] uframeIdx;
  logic [FRAME_W-1:0] frameNum;

  // Software state
  logic ctrlEn_q, ctrlEn_d;
  logic ctrlDirIn_q, ctrlDirIn_d;
  logic [MASK_W-1:0] uframe_activity_mask_q, uframe_activity_mask_d;
  logic [DFN_W-1:0] descriptor_frame_number_q, descriptor_frame_number_d;
  logic [IRQ_W-1:0] irqMask_q, irqMask_d;

  // Hardware-owned state
  logic [MASK_W*RESULT_W-1:0] results_q, results_d;
  logic [UFRAME_IDX_W-1:0] slot_q, slot_d;
  logic start_q, start_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;

  logic frameMatch;
  logic issue;
  logic wrAcc, rdAcc, mapped;
  logic [IRQ_W-1:0] irqEvents;
  logic [MASK_W-1:0] hwClear;
  logic [31:0] descWord;

  pis_uframe_timer #(
    .UFRAME_CYCLES(UFRAME_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(ctrlEn_q),
    .uframeTick(uframeTick),
    .uframeIdx(uframeIdx),
    .frameNum(frameNum)
  );

  pis_txn_seq u_seq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tx(tx.seq),
    .linkReq(linkReq),
    .linkDirIn(linkDirIn),
    .linkDone(linkDone),
    .linkErr(linkErr),
    .linkBabble(linkBabble),
    .linkUnderrun(linkUnderrun)
  );

  // Only the low frame bits are held in the descriptor
  assign frameMatch = (descriptor_frame_number_q == frameNum[DFN_W-1:0]); // RULE5

  // Mask bit n gates microframe n; all ones gives every microframe
  assign issue = ctrlEn_q && uframeTick && frameMatch && !tx.busy
    && uframe_activity_mask_q[uframeIdx]; // RULE5 RULE6 RULE7

  assign descWord = {results_q, uframe_activity_mask_q};

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign mapped = (paddr == CTRL_OFS) || (paddr == DESC_OFS)
    || (paddr == DFRAME_OFS) || (paddr == CURFRAME_OFS)
    || (paddr == IRQ_STAT_OFS) || (paddr == IRQ_MASK_OFS);

  // Scheduler: launch and completion bookkeeping
  always_comb begin
    slot_d = slot_q;
    start_d = 1'b0;
    results_d = results_q;
    hwClear = '0;
    irqEvents = '0;
    if (issue) begin
      slot_d = uframeIdx;
      start_d = 1'b1;
    end
    if (tx.done) begin
      // Field updated only after the sequencer reports completion
      results_d[resultLsb(slot_q)-RESULT_LSB +: RESULT_W] = tx.result; // RULE1 RULE2
      hwClear[slot_q] = 1'b1; // RULE4
      irqEvents[IRQ_DONE_BIT] = 1'b1;
      irqEvents[IRQ_ERR_BIT] = |tx.result;
      if ((uframe_activity_mask_q & ~hwClear) == '0) begin
        irqEvents[IRQ_EMPTY_BIT] = 1'b1;
      end
    end
  end

  // Software writes
  always_comb begin
    ctrlEn_d = ctrlEn_q;
    ctrlDirIn_d = ctrlDirIn_q;
    descriptor_frame_number_d = descriptor_frame_number_q;
    irqMask_d = irqMask_q;
    // A set from software in the same cycle as the hardware clear wins
    uframe_activity_mask_d = uframe_activity_mask_q & ~hwClear; // RULE4
    if (wrAcc && (paddr == DESC_OFS)) begin
      // Software can only raise mask bits; result bits ignore writes
      uframe_activity_mask_d = uframe_activity_mask_d
        | pwdata[MASK_LSB +: MASK_W]; // RULE4
    end
    if (isAccess(CTRL_OFS) && pwrite) begin
      ctrlEn_d = pwdata[CTRL_EN_BIT];
      ctrlDirIn_d = pwdata[CTRL_DIRIN_BIT];
    end
    if (isAccess(DFRAME_OFS) && pwrite) begin
      descriptor_frame_number_d = pwdata[DFN_LSB +: DFN_W];
    end
    if (isAccess(IRQ_MASK_OFS) && pwrite) begin
      irqMask_d = pwdata[IRQ_W-1:0];
    end
  end

  // Interrupt status: write one to clear, new events win over the clear
  always_comb begin
    irqStat_d = irqStat_q;
    if (isAccess(IRQ_STAT_OFS) && pwrite) begin
      irqStat_d = irqStat_d & ~pwdata[IRQ_W-1:0];
    end
    irqStat_d = irqStat_d | irqEvents;
  end

  // Read data and error answer, zero wait states
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      prdata_d = '0;
      pslverr_d = !mapped;
      if (!pwrite) begin
        unique case (paddr)
          CTRL_OFS: begin
            prdata_d[CTRL_EN_BIT] = ctrlEn_q;
            prdata_d[CTRL_DIRIN_BIT] = ctrlDirIn_q;
          end
          DESC_OFS: prdata_d = descWord;
          DFRAME_OFS: prdata_d[DFN_LSB +: DFN_W] = descriptor_frame_number_q;
          CURFRAME_OFS: prdata_d[FRAME_W-1:0] = frameNum;
          IRQ_STAT_OFS: prdata_d[IRQ_W-1:0] = irqStat_q;
          IRQ_MASK_OFS: prdata_d[IRQ_W-1:0] = irqMask_q;
          default: prdata_d = '0;
        endcase
      end
    end else if (rdAcc || wrAcc) begin
      pslverr_d = pslverr_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlEn_q <= 1'b0;
      ctrlDirIn_q <= 1'b0;
      uframe_activity_mask_q <= RESET_WORD[MASK_W-1:0];
      descriptor_frame_number_q <= RESET_WORD[DFN_W-1:0];
      irqMask_q <= RESET_WORD[IRQ_W-1:0];
      results_q <= RESET_WORD[MASK_W*RESULT_W-1:0];
      slot_q <= '0;
      start_q <= 1'b0;
      irqStat_q <= RESET_WORD[IRQ_W-1:0];
      prdata_q <= RESET_WORD;
      pslverr_q <= 1'b0;
    end else begin
      ctrlEn_q <= ctrlEn_d;
      ctrlDirIn_q <= ctrlDirIn_d;
      uframe_activity_mask_q <= uframe_activity_mask_d;
      descriptor_frame_number_q <= descriptor_frame_number_d;
      irqMask_q <= irqMask_d;
      results_q <= results_d;
      slot_q <= slot_d;
      start_q <= start_d;
      irqStat_q <= irqStat_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign tx.start = start_q;
  assign tx.dirIn = ctrlDirIn_q;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign irq = |(irqStat_q & irqMask_q);
endmodule
`default_nettype wire

// file: test/pis_uframe_sched_sva.sv
// Port-level assertions for the microframe scheduler
`timescale 1ns/1ps
`default_nettype none
module pis_sched_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic linkReq,
  input wire logic linkDirIn,
  input wire logic linkDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_req_hold; linkReq && !linkDone |=> linkReq; endproperty
  a_req_hold: assert property (p_req_hold) else $error("link request dropped early");
  property p_req_drop; linkReq && linkDone |=> !linkReq; endproperty
  a_req_drop: assert property (p_req_drop) else $error("link request held past done");
  property p_dir_stable; linkReq && $past(linkReq) |-> $stable(linkDirIn); endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved mid transfer");
  property p_req_gap; $fell(linkReq) |-> !linkReq [*2]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("request reissued too soon");
  property p_irq_cause;
    $rose(irq) |-> $past(linkDone, 2) || $past(psel && penable && pwrite);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_rst_quiet; $fell(sys_rst) |-> !linkReq && !irq && !linkDirIn; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_err_map;
    psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014);
  endproperty
  a_err_map: assert property (p_err_map) else $error("slave error flag wrong");
  property p_ready; psel && penable |-> pready && (!pslverr || $past(psel)); endproperty
  a_ready: assert property (p_ready) else $error("access not completed at once");
  c_req: cover property ($rose(linkReq));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule
bind pis_uframe_sched pis_sched_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .irq(irq), .linkReq(linkReq), .linkDirIn(linkDirIn), .linkDone(linkDone));
`default_nettype wire

// file: test/pis_link_model.sv
// Far-end link model: answers each request after a set delay
`timescale 1ns/1ps
`default_nettype none
module pis_link_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic linkReq,
  input wire logic [3:0] delay,
  input wire logic [2:0] flags,
  output logic linkDone,
  output logic linkErr,
  output logic linkBabble,
  output logic linkUnderrun
);
  logic [3:0] cnt_q;
  // Outside done the flags are inverted so a stale sample cannot match
  assign linkErr = linkDone ? flags[0] : !flags[0];
  assign linkBabble = linkDone ? flags[1] : !flags[1];
  assign linkUnderrun = linkDone ? flags[2] : !flags[2];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      linkDone <= 1'h0;
    end else begin
      linkDone <= linkReq && !linkDone && cnt_q == delay;
      cnt_q <= (linkReq && !linkDone && cnt_q != delay) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: test/pis_uframe_sched_test.sv
// Self-checking bench for the microframe scheduler
`timescale 1ns/1ps
`default_nettype none
module pis_uframe_sched_test;
  import pis_pkg::*;
  logic mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, linkReq, linkDirIn, linkDone, linkErr, linkBabble, linkUnderrun;
  logic er, reqPrev = 1'h0, dirSeen = 1'h0;
  logic [3:0] delay = 4'h2;
  logic [2:0] flags = 3'h7;
  int mismatches = 0, n_tests = 0, rises = 0, cycles = 0;
  pis_uframe_sched #(.UFRAME_CYCLES(20)) uut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .linkReq(linkReq), .linkDirIn(linkDirIn),
    .linkDone(linkDone), .linkErr(linkErr), .linkBabble(linkBabble),
    .linkUnderrun(linkUnderrun));
  pis_link_model u_link (.mclk(mclk), .sys_rst(sys_rst), .linkReq(linkReq), .delay(delay),
    .flags(flags), .linkDone(linkDone), .linkErr(linkErr), .linkBabble(linkBabble),
    .linkUnderrun(linkUnderrun));
  always #12.5 mclk = !mclk;
  always @(posedge mclk) begin
    reqPrev <= linkReq;
    if (linkReq === 1'h1 && reqPrev === 1'h0) begin
      rises <= rises + 1;
      dirSeen <= linkDirIn;
    end
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'h0;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, '0);
    chk(nm, e, rd);
  endtask
  task automatic do_reset();
    sys_rst <= 1'h1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
  endtask
  task automatic t_reset_map();
    rd_chk("desc reset", DESC_OFS, 32'h0);
    apb(1'h0, 12'h018, '0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, er});
  endtask
  // All eight microframes, IN, every flag raised by the far end
  task automatic t_all_uframes();
    apb(1'h1, DFRAME_OFS, 32'h0);
    apb(1'h1, DESC_OFS, 32'hff);
    apb(1'h1, IRQ_MASK_OFS, 32'h1);
    rises = 0;
    apb(1'h1, CTRL_OFS, 32'h3);
    repeat (190) @(posedge mclk);
    chk("rises all", 32'h8, rises);
    chk("dir in", 32'h1, {31'h0, dirSeen});
    rd_chk("desc all", DESC_OFS, 32'h6db6_db00);
    chk("irq set", 32'h1, {31'h0, irq});
    rd_chk("irq status", IRQ_STAT_OFS, 32'h7);
    apb(1'h1, IRQ_STAT_OFS, 32'h1);
    rd_chk("irq status cleared", IRQ_STAT_OFS, 32'h6);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("ctrl", CTRL_OFS, 32'h3);
  endtask
  // Sparse mask, OUT, descriptor waits for frame 2
  task automatic t_sparse();
    do_reset();
    delay <= 4'h4;
    apb(1'h1, DFRAME_OFS, 32'h10);
    apb(1'h1, DESC_OFS, 32'h11);
    apb(1'h1, DESC_OFS, 32'h0);
    rd_chk("mask or set", DESC_OFS, 32'h11);
    rd_chk("dframe", DFRAME_OFS, 32'h10);
    rises = 0;
    apb(1'h1, CTRL_OFS, 32'h1);
    repeat (170) @(posedge mclk);
    chk("rises mismatch", 32'h0, rises);
    repeat (340) @(posedge mclk);
    chk("rises sparse", 32'h2, rises);
    chk("dir out", 32'h0, {31'h0, dirSeen});
    rd_chk("desc sparse", DESC_OFS, 32'h0050_0500);
    rd_chk("cur frame", CURFRAME_OFS, 32'h3);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    t_reset_map();
    t_all_uframes();
    t_sparse();
    give_verdict();
  end
endmodule
`default_nettype wire
